//--- dv/atc_tag_model.sv
// Behavioural actuator transponder that faces the teach-in controller.
`timescale 1ns/1ps
module atc_tag_model (
   input  wire logic        hclk,
   input  wire logic        want_on,
   input  wire logic [31:0] want_id,
   output atc_pkg::atc_tag_t tag
);
   initial tag = '0;
   always @(posedge hclk) begin
      if (want_on) begin
         tag <= {1'b1, 1'b1, want_id};
      end else begin
         tag <= {1'b0, 1'b0, ~tag.id};
      end
   end
endmodule

//--- dv/test_actuator_teach_in_control.sv
// Self-checking bench of the actuator teach-in controller.
`timescale 1ns/1ps
module test_actuator_teach_in_control;
   logic              hclk = 1'b0;
   logic              hresetn = 1'b0;
   logic              nv_rst_n = 1'b0;
   logic              hsel = 1'b0;
   logic [1:0]        htrans = 2'h0;
   logic              hwrite = 1'b0;
   logic [2:0]        hsize = 3'h2;
   logic              want_on = 1'b0;
   logic [31:0]       haddr = 32'h0;
   logic [31:0]       hwdata = 32'h0;
   logic [31:0]       want_id = 32'h0;
   logic [31:0]       rnd = 32'hd8fce9af;
   logic [31:0]       hrdata, rd, tid_m, a;
   logic              hready, hreadyout, hresp, gate_led, actuator_valid, irq;
   atc_pkg::atc_tag_t tag;
   logic [31:0]       hist[$];
   int                n_mismatch = 0;
   int                cmp_count = 0;
   int                cyc = 0;
   int                var_m, rem_m, taught_m, k;

   assign hready = hreadyout;
   initial forever #5 hclk = ~hclk;

   atc_top #(.WAIT_CYC(40), .COMMIT_CYC(100), .SLOW_ON_CYC(5),
      .QUICK_ON_CYC(2), .QUICK_OFF_CYC(8)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .nv_rst_n(nv_rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .tag(tag), .gate_led(gate_led),
      .actuator_valid(actuator_valid), .irq(irq));

   atc_tag_model i_tag (.hclk(hclk), .want_on(want_on),
      .want_id(want_id), .tag(tag));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic give_verdict();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] ad,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, hresp);
   endtask

   task automatic set_tag(input logic on, input logic [31:0] id);
      @(posedge hclk);
      want_on <= on;
      want_id <= id;
   endtask

   task automatic cnt(input int n);
      k = 0;
      repeat (n) begin
         @(posedge hclk);
         #1;
         k += (gate_led === 1'b1);
      end
   endtask

   task automatic pwr();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask

   task automatic st_chk();
      bus(1'b0, atc_pkg::OFF_STAT, 32'h0);
      chk("taught", taught_m, rd[atc_pkg::ST_TAUGHT_B]);
      chk("variant", var_m, rd[atc_pkg::ST_VAR_LSB +: 2]);
      if (var_m != 0) chk("remain", rem_m, rd[atc_pkg::ST_REM_LSB +: 4]);
      bus(1'b0, atc_pkg::OFF_ID, 32'h0);
      if (taught_m != 0) chk("id", tid_m, rd);
   endtask

   task automatic first();
      bus(1'b1, atc_pkg::OFF_MASK, 32'h0);
      rnd = lfsr(rnd);
      set_tag(1'b1, rnd);
      repeat (4) @(posedge hclk);
      #1;
      chk("irq_masked", 0, irq);
      bus(1'b1, atc_pkg::OFF_MASK, 32'h1);
      #1;
      chk("irq", 1, irq);
      bus(1'b0, atc_pkg::OFF_IRQ, 32'h0);
      chk("irq_taught", 1, rd[atc_pkg::EV_TAUGHT]);
      #1;
      chk("irq_clear", 0, irq);
      tid_m = rnd;
      taught_m = 1;
      rem_m--;
      chk("valid", 1, actuator_valid);
      chk("led", 1, gate_led);
      st_chk();
   endtask

   task automatic reteach(input logic [31:0] id, input int mode);
      int ok;
      ok = var_m == 1 && rem_m > 0 && id != tid_m && !(id inside {hist});
      set_tag(1'b1, id);
      repeat (3) @(posedge hclk);
      cnt(10);
      chk("slow", ok ? 5 : 0, k);
      if (mode == 1) begin
         set_tag(1'b0, id);
         repeat (5) @(posedge hclk);
      end else begin
         repeat (35) @(posedge hclk);
         cnt(10);
         chk("quick", ok ? 2 : 0, k);
         if (mode == 2) repeat (150) @(posedge hclk);
      end
      pwr();
      if (ok != 0 && mode == 0) begin
         hist.push_back(tid_m);
         tid_m = id;
         rem_m--;
      end
      #1;
      chk("valid", tid_m == id && mode != 1, actuator_valid);
      bus(1'b0, atc_pkg::OFF_IRQ, 32'h0);
      chk("done", ok != 0 && mode == 0, rd[atc_pkg::EV_DONE]);
      chk("refuse", ok == 0, rd[atc_pkg::EV_REFUSE]);
      st_chk();
      set_tag(1'b0, id);
      repeat (3) @(posedge hclk);
   endtask

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial begin
      tid_m = 32'h0;
      taught_m = 0;
      var_m = 1;
      rem_m = 8;
      repeat (12) @(posedge hclk);
      nv_rst_n <= 1'b1;
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      st_chk();
      bus(1'b1, atc_pkg::OFF_CFG, 32'h0);
      var_m = 0;
      rnd = lfsr(rnd);
      set_tag(1'b1, rnd);
      repeat (3) @(posedge hclk);
      #1;
      chk("open_valid", 1, actuator_valid);
      chk("open_led", 1, gate_led);
      st_chk();
      bus(1'b0, 32'h20, 32'h0);
      chk("unmapped", 0, rd);
      set_tag(1'b0, rnd);
      bus(1'b1, atc_pkg::OFF_CFG, 32'h2);
      var_m = 2;
      rem_m = 1;
      first();
      cnt(10);
      chk("steady", 10, k);
      rnd = lfsr(rnd);
      reteach(rnd, 0);
      @(posedge hclk);
      nv_rst_n <= 1'b0;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      nv_rst_n <= 1'b1;
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      var_m = 1;
      rem_m = 8;
      taught_m = 0;
      hist.delete();
      st_chk();
      first();
      a = tid_m;
      rnd = lfsr(rnd);
      reteach(rnd, 0);
      reteach(a, 0);
      rnd = lfsr(rnd);
      reteach(rnd, 1);
      rnd = lfsr(rnd);
      reteach(rnd, 2);
      for (int i = 0; i < 7; i++) begin
         rnd = lfsr(rnd);
         reteach(rnd, 0);
      end
      give_verdict();
   end
endmodule

//--- logic/atc_pkg.sv
// Package of constants and types for the actuator teach-in controller.
package atc_pkg;

   localparam int unsigned ID_W   = 32;
   localparam int unsigned TMR_W  = 34;
   localparam int unsigned EV_W   = 6;
   localparam int unsigned HIST_N = 8;
   localparam int unsigned CNT_W  = 4;

   // Register byte offsets.
   localparam logic [31:0] OFF_CFG  = 32'h0000_0000;
   localparam logic [31:0] OFF_STAT = 32'h0000_0004;
   localparam logic [31:0] OFF_ID   = 32'h0000_0008;
   localparam logic [31:0] OFF_IRQ  = 32'h0000_000c;
   localparam logic [31:0] OFF_MASK = 32'h0000_0010;

   // Status register field positions.
   localparam int unsigned ST_VALID_B = 0;
   localparam int unsigned ST_TAUGHT_B = 1;
   localparam int unsigned ST_LED_B   = 2;
   localparam int unsigned ST_SLOW_B  = 3;
   localparam int unsigned ST_QUICK_B = 4;
   localparam int unsigned ST_PEND_B  = 5;
   localparam int unsigned ST_REM_LSB = 8;
   localparam int unsigned ST_VAR_LSB = 16;

   // Event bit positions in the interrupt status and mask registers.
   localparam int unsigned EV_TAUGHT = 0;
   localparam int unsigned EV_START  = 1;
   localparam int unsigned EV_READY  = 2;
   localparam int unsigned EV_DONE   = 3;
   localparam int unsigned EV_ABORT  = 4;
   localparam int unsigned EV_REFUSE = 5;

   localparam logic [CNT_W-1:0] TEACH_MAX_SINGLE = 4'h8;
   localparam logic [CNT_W-1:0] TEACH_MAX_ONCE   = 4'h1;

   // Timing in the printed units and derived clock counts.
   localparam longint unsigned CLK_NS       = 64'd10;
   localparam longint unsigned NS_PER_S     = 64'd1000000000;
   localparam longint unsigned NS_PER_MS    = 64'd1000000;
   localparam longint unsigned WAIT_S       = 64'd20;
   localparam longint unsigned COMMIT_S     = 64'd120;
   localparam longint unsigned SLOW_ON_MS   = 64'd500;
   localparam longint unsigned SLOW_OFF_MS  = 64'd500;
   localparam longint unsigned QUICK_ON_MS  = 64'd50;
   localparam longint unsigned QUICK_OFF_MS = 64'd950;
   localparam longint unsigned WAIT_CYC =
      (WAIT_S * NS_PER_S + CLK_NS - 64'd1) / CLK_NS;
   localparam longint unsigned COMMIT_CYC = COMMIT_S * NS_PER_S / CLK_NS;
   localparam longint unsigned SLOW_ON_CYC = SLOW_ON_MS * NS_PER_MS / CLK_NS;
   localparam longint unsigned SLOW_OFF_CYC =
      SLOW_OFF_MS * NS_PER_MS / CLK_NS;
   localparam longint unsigned QUICK_ON_CYC =
      QUICK_ON_MS * NS_PER_MS / CLK_NS;
   localparam longint unsigned QUICK_OFF_CYC =
      QUICK_OFF_MS * NS_PER_MS / CLK_NS;

   typedef enum logic [1:0] {
      VAR_OPEN   = 2'h0,
      VAR_SINGLE = 2'h1,
      VAR_ONCE   = 2'h2
   } atc_var_t;

   localparam atc_var_t VAR_RESET = VAR_SINGLE;

   typedef enum {ST_IDLE, ST_SLOW, ST_QUICK, ST_HOLD} atc_state_t;

   typedef struct packed {
      logic            present;
      logic            single;
      logic [ID_W-1:0] id;
   } atc_tag_t;

endpackage

//--- logic/atc_top.sv
// Actuator teach-in controller with AHB-Lite registers and gate indicator.
`timescale 1ns/1ps

module atc_top #(
   parameter longint unsigned WAIT_CYC      = atc_pkg::WAIT_CYC,
   parameter longint unsigned COMMIT_CYC    = atc_pkg::COMMIT_CYC,
   parameter longint unsigned SLOW_ON_CYC   = atc_pkg::SLOW_ON_CYC,
   parameter longint unsigned SLOW_OFF_CYC  =
      SLOW_ON_CYC * atc_pkg::SLOW_OFF_MS / atc_pkg::SLOW_ON_MS,
   parameter longint unsigned QUICK_ON_CYC  = atc_pkg::QUICK_ON_CYC,
   parameter longint unsigned QUICK_OFF_CYC = atc_pkg::QUICK_OFF_CYC
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              nv_rst_n,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  atc_pkg::atc_tag_t      tag,
   output logic                   gate_led,
   output logic                   actuator_valid,
   output logic                   irq
);
   localparam int unsigned TW = atc_pkg::TMR_W;
   localparam int unsigned CW = atc_pkg::CNT_W;
   localparam int unsigned IW = atc_pkg::ID_W;

   function automatic logic reg_hit(input logic [31:0] a,
                                    input logic [31:0] off);
      reg_hit = (a == off);
   endfunction

   atc_pkg::atc_state_t state_q, state_d;
   logic [TW-1:0]       tmr_q, fl_q;
   logic [IW-1:0]       cand_q;
   logic                rel_q, rel2_q, led_q, valid_q;
   logic                acc_wr_q;
   logic [31:0]         addr_q, hrdata_q;
   logic [atc_pkg::EV_W-1:0] irq_q, mask_q;
   // Retained state, cleared only by the non-volatile reset.
   atc_pkg::atc_var_t   var_q;
   logic                taught_q, pend_q;
   logic [IW-1:0]       tid_q, pend_id_q;
   logic [CW-1:0]       rem_q, hcnt_q;
   logic [IW-1:0]       hist_q [atc_pkg::HIST_N];

   // Commit runs once at the second edge after reset release.
   wire run       = rel2_q;
   wire boot      = rel_q & ~rel2_q;
   wire coded     = var_q != atc_pkg::VAR_OPEN;
   wire is_single = var_q == atc_pkg::VAR_SINGLE;
   wire id_match  = tag.present & taught_q & (tag.id == tid_q);
   wire valid_now = tag.present & (~coded | id_match);

   logic [atc_pkg::HIST_N-1:0] hit_v;
   for (genvar g = 0; g < atc_pkg::HIST_N; g++) begin : g_hist
      assign hit_v[g] = (CW'(g) < hcnt_q) & (hist_q[g] == tag.id);
   end
   wire in_hist = |hit_v;

   wire in_idle   = run & (state_q == atc_pkg::ST_IDLE);
   wire unknown   = in_idle & tag.present & coded & ~valid_now;
   wire auto_tch  = unknown & ~taught_q & tag.single;
   wire can_re    = is_single & (rem_q != '0);
   wire start     = unknown & taught_q & tag.single & can_re & ~in_hist;
   wire refuse    = unknown & ~auto_tch & ~start;
   wire cand_ok   = tag.present & (tag.id == cand_q);
   wire wait_end  = tmr_q == TW'(WAIT_CYC - 64'd1);
   wire win_end   = tmr_q == TW'(COMMIT_CYC - 64'd1);
   wire in_slow   = run & (state_q == atc_pkg::ST_SLOW);
   wire in_quick  = run & (state_q == atc_pkg::ST_QUICK);
   wire go_quick  = in_slow & cand_ok & wait_end;
   wire abort     = (in_slow & ~cand_ok) | (in_quick & (~cand_ok | win_end));
   wire commit    = boot & pend_q & can_re;
   wire teach     = auto_tch | commit;
   wire [IW-1:0] teach_id = commit ? pend_id_q : tag.id;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         atc_pkg::ST_IDLE: begin
            if (start) begin
               state_d = atc_pkg::ST_SLOW;
            end else if (refuse) begin
               state_d = atc_pkg::ST_HOLD;
            end
         end
         atc_pkg::ST_SLOW: begin
            if (abort) begin
               state_d = atc_pkg::ST_HOLD;
            end else if (go_quick) begin
               state_d = atc_pkg::ST_QUICK;
            end
         end
         atc_pkg::ST_QUICK: begin
            if (abort) begin
               state_d = atc_pkg::ST_HOLD;
            end
         end
         atc_pkg::ST_HOLD: begin
            if (~tag.present | valid_now) begin
               state_d = atc_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= atc_pkg::ST_IDLE;
         tmr_q   <= '0;
         cand_q  <= '0;
         rel_q   <= 1'b0;
         rel2_q  <= 1'b0;
      end else begin
         rel_q   <= 1'b1;
         rel2_q  <= rel_q;
         state_q <= run ? state_d : atc_pkg::ST_IDLE;
         tmr_q   <= (state_d != state_q) ? '0 : tmr_q + TW'(1);
         if (start) begin
            cand_q <= tag.id;
         end
      end
   end

   wire slow_end  = fl_q == TW'(SLOW_ON_CYC + SLOW_OFF_CYC - 64'd1);
   wire quick_end = fl_q == TW'(QUICK_ON_CYC + QUICK_OFF_CYC - 64'd1);
   wire fl_wrap   = (state_q == atc_pkg::ST_SLOW) ? slow_end : quick_end;
   wire slow_on   = fl_q < TW'(SLOW_ON_CYC);
   wire quick_on  = fl_q < TW'(QUICK_ON_CYC);
   wire led_d = (state_q == atc_pkg::ST_SLOW)  ? slow_on :
                (state_q == atc_pkg::ST_QUICK) ? quick_on : valid_now;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fl_q    <= '0;
         led_q   <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         fl_q    <= (state_d != state_q || fl_wrap) ? '0 : fl_q + TW'(1);
         led_q   <= run & led_d;
         valid_q <= run & valid_now;
      end
   end

   // AHB-Lite slave, zero wait states.
   wire acc    = hsel & htrans[1] & hready;
   wire rd_acc = acc & ~hwrite;
   wire wr_cfg = acc_wr_q & reg_hit(addr_q, atc_pkg::OFF_CFG);
   wire wr_msk = acc_wr_q & reg_hit(addr_q, atc_pkg::OFF_MASK);
   wire rd_irq = rd_acc & reg_hit(haddr, atc_pkg::OFF_IRQ);
   wire [atc_pkg::EV_W-1:0] ev = {refuse, abort, commit, go_quick, start,
                                  teach};
   wire [31:0] stat_v =
      (32'(valid_now) << atc_pkg::ST_VALID_B) |
      (32'(taught_q)  << atc_pkg::ST_TAUGHT_B) |
      (32'(led_q)     << atc_pkg::ST_LED_B) |
      (32'(state_q == atc_pkg::ST_SLOW)  << atc_pkg::ST_SLOW_B) |
      (32'(state_q == atc_pkg::ST_QUICK) << atc_pkg::ST_QUICK_B) |
      (32'(pend_q)    << atc_pkg::ST_PEND_B) |
      (32'(rem_q)     << atc_pkg::ST_REM_LSB) |
      (32'(var_q)     << atc_pkg::ST_VAR_LSB);
   wire [31:0] rdata_d =
      reg_hit(haddr, atc_pkg::OFF_CFG)  ? 32'(var_q) :
      reg_hit(haddr, atc_pkg::OFF_STAT) ? stat_v :
      reg_hit(haddr, atc_pkg::OFF_ID)   ? tid_q :
      reg_hit(haddr, atc_pkg::OFF_IRQ)  ? 32'(irq_q) :
      reg_hit(haddr, atc_pkg::OFF_MASK) ? 32'(mask_q) : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_wr_q <= 1'b0;
         addr_q   <= '0;
         hrdata_q <= '0;
         irq_q    <= '0;
         mask_q   <= '0;
      end else begin
         acc_wr_q <= acc & hwrite;
         if (acc) begin
            addr_q <= haddr;
         end
         if (rd_acc) begin
            hrdata_q <= rdata_d;
         end
         irq_q <= (rd_irq ? '0 : irq_q) | ev;
         if (wr_msk) begin
            mask_q <= hwdata[atc_pkg::EV_W-1:0];
         end
      end
   end

   // Retained teach state survives the system reset.
   always_ff @(posedge hclk or negedge nv_rst_n) begin
      if (!nv_rst_n) begin
         var_q     <= atc_pkg::VAR_RESET;
         taught_q  <= 1'b0;
         pend_q    <= 1'b0;
         tid_q     <= '0;
         pend_id_q <= '0;
         rem_q     <= atc_pkg::TEACH_MAX_SINGLE;
         hcnt_q    <= '0;
         for (int i = 0; i < atc_pkg::HIST_N; i++) begin
            hist_q[i] <= '0;
         end
      end else begin
         if (wr_cfg && !taught_q) begin
            var_q <= atc_pkg::atc_var_t'(hwdata[1:0]);
            rem_q <= (hwdata[1:0] == atc_pkg::VAR_ONCE) ?
                     atc_pkg::TEACH_MAX_ONCE : atc_pkg::TEACH_MAX_SINGLE;
         end
         if (teach) begin
            taught_q <= 1'b1;
            tid_q    <= teach_id;
            rem_q    <= rem_q - CW'(1);
         end
         if (commit) begin
            hist_q[hcnt_q[2:0]] <= tid_q;
            hcnt_q <= hcnt_q + CW'(1);
         end
         if (go_quick) begin
            pend_q    <= 1'b1;
            pend_id_q <= cand_q;
         end else if (abort || boot) begin
            pend_q <= 1'b0;
         end
      end
   end

   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign hrdata         = hrdata_q;
   assign gate_led       = led_q;
   assign actuator_valid = valid_q;
   assign irq            = |(irq_q & mask_q);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   open_accept_a: assert property (run && !coded && tag.present |=>
      actuator_valid) else $error("open actuator not valid");
   teach_limit_a: assert property (rem_q <= atc_pkg::TEACH_MAX_SINGLE)
      else $error("teach counter above limit");
   once_locked_a: assert property (var_q == atc_pkg::VAR_ONCE &&
      taught_q |-> !start) else $error("one-time switch re-teaching");
   auto_teach_a: assert property (auto_tch |=> taught_q &&
      tid_q == $past(tag.id)) else $error("first actuator not taught");
   slow_flash_a: assert property (start |=>
      state_q == atc_pkg::ST_SLOW ##1 gate_led) else $error("no slow flash");
   quick_go_a: assert property (go_quick |=>
      state_q == atc_pkg::ST_QUICK && pend_q) else $error("no quick flash");
   commit_dec_a: assert property (commit |=>
      rem_q == $past(rem_q) - CW'(1) && tid_q == $past(pend_id_q))
      else $error("commit did not store actuator");
   replaced_ref_a: assert property (start |-> !in_hist)
      else $error("replaced actuator re-taught");
   abort_keep_a: assert property (abort && !go_quick |=>
      !pend_q && $stable(rem_q) && $stable(tid_q))
      else $error("abort changed taught state");
   zero_ignore_a: assert property (rem_q == '0 |-> !start && !commit)
      else $error("teach with counter at zero");
   refuse_hold_a: assert property (refuse |=>
      state_q == atc_pkg::ST_HOLD) else $error("refused actuator not held");
   valid_led_a: assert property (in_idle && valid_now |=> gate_led)
      else $error("indicator dark for valid actuator");

   reteach_c: cover property (start ##1 in_slow [*3]);
   commit_c: cover property (commit);
   refuse_c: cover property (refuse ##1 state_q == atc_pkg::ST_HOLD);
   abort_c: cover property (abort ##1 state_q == atc_pkg::ST_HOLD);
endmodule
